// ---- bench/ptc_props.sv ----
`timescale 1ns/1ps
// Watches the trap latch, output mapping and register reads at the top ports.
module ptc_props (
    input wire logic [11:0] i_paddr,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_mclk,
    input wire logic        i_nrst,
    input wire logic        i_emergency_trap_pin,
    input wire logic [5:0]  i_pwm_raw,
    input wire logic [5:0]  o_pwm,
    input wire logic        o_trap_active
);
    logic       pol_q;
    logic [5:0] ena_q;
    logic [5:0] act_q;
    logic       wr;
    logic       rd;
    logic       unmap;
    // Bus phase decode.
    assign wr = i_psel && i_penable && i_pwrite;
    assign rd = i_psel && !i_penable && !i_pwrite;
    assign unmap = i_paddr > 12'h01C;
    // Mirror of the settings software wrote, so expectations follow them.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            pol_q <= 1'h1;
            ena_q <= 6'h3F;
            act_q <= 6'h3F;
        end else if (wr && i_paddr == 12'h000) begin
            pol_q <= i_pwdata[16];
            ena_q <= i_pwdata[5:0];
        end else if (wr && i_paddr == 12'h00C) begin
            act_q <= i_pwdata[5:0];
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    pready_on_a: assert property ($past(i_nrst) |-> o_pready)
        else $error("ready low after reset");
    trap_rise_a: assert property (pol_q && $rose(i_emergency_trap_pin) ##0
        i_emergency_trap_pin [*3] |=> o_trap_active) else $error("rising trap missed");
    trap_fall_a: assert property (!pol_q && $fell(i_emergency_trap_pin) ##0
        !i_emergency_trap_pin [*3] |=> o_trap_active) else $error("falling trap missed");
    trap_out_a: assert property (o_trap_active && $past(i_nrst) && $stable(act_q)
        && $stable(ena_q) |-> o_pwm == ((($past(i_pwm_raw) ~^ act_q) & ~ena_q) | (~act_q & ena_q)))
        else $error("trapped outputs wrong");
    pwm_pass_a: assert property (!o_trap_active && $past(i_nrst) && $stable(act_q)
        |-> o_pwm == ($past(i_pwm_raw) ~^ act_q)) else $error("output level map wrong");
    trap_release_a: assert property ((i_emergency_trap_pin != pol_q) [*4]
        |-> !o_trap_active) else $error("trap held while inactive");
    unmapped_err_a: assert property (rd && i_paddr[1:0] == 2'h0
        |=> o_pslverr == $past(unmap)) else $error("error response wrong");
    trap_read_a: assert property (rd && i_paddr == 12'h000
        |=> o_prdata == {15'h0, pol_q, 10'h0, ena_q}) else $error("trap register read wrong");
    resv_zero_a: assert property (rd && (i_paddr == 12'h004 || i_paddr == 12'h008)
        |=> o_prdata[31:8] == 24'h00_0000) else $error("reserved bits not zero");
    act_read_a: assert property (rd && i_paddr == 12'h00C
        |=> o_prdata == {26'h0, act_q}) else $error("active level read wrong");
    cover property (pol_q && $rose(o_trap_active));
    cover property (!pol_q && $rose(o_trap_active));
    cover property (rd && unmap);
endmodule : ptc_props

// ---- bench/ptc_src_model.sv ----
`timescale 1ns/1ps
// Drives the trap, capture, sync and transfer lines; all change just after a clock edge.
module ptc_src_model (
    input  wire logic       i_mclk,
    output logic            o_trap,
    output logic      [2:0] o_cap,
    output logic            o_sync,
    output logic            o_trans
);
    // All lines start low.
    initial begin
        o_trap  = 1'b0;
        o_cap   = 3'h0;
        o_sync  = 1'b0;
        o_trans = 1'b0;
    end
    // Sets the line vector {trans, sync, cap2, cap1, cap0, trap} at the next edge.
    task drive(input logic [5:0] v);
        @(posedge i_mclk);
        o_trap  <= v[0];
        o_cap   <= v[3:1];
        o_sync  <= v[4];
        o_trans <= v[5];
    endtask : drive
endmodule : ptc_src_model

// ---- bench/tb_pwm_trap_and_capture_control.sv ----
`timescale 1ns/1ps
// Directed bench for the trap and capture front end.
module tb_pwm_trap_and_capture_control;
    logic [11:0] i_paddr;
    logic        i_psel, i_penable, i_pwrite, i_nrst, i_emergency_trap_pin;
    logic [31:0] i_pwdata, o_prdata;
    logic        o_pready, o_pslverr, i_sync_in, i_trans_enable_in, o_trap_active;
    logic [2:0]  i_external_capture_pin;
    logic [15:0] i_pwm_counter_value;
    logic [5:0]  i_pwm_raw, o_pwm;
    logic        i_mclk = 1'b0;
    int          failures = 0;
    int          checks = 0;
    // Clock of 4 ns period.
    always #2 i_mclk = ~i_mclk;
    ptc_top dut (.i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_mclk, .i_nrst, .i_emergency_trap_pin, .i_external_capture_pin,
        .i_sync_in, .i_trans_enable_in, .i_pwm_counter_value, .i_pwm_raw, .o_pwm, .o_trap_active);
    ptc_src_model src (.i_mclk, .o_trap(i_emergency_trap_pin), .o_cap(i_external_capture_pin),
        .o_sync(i_sync_in), .o_trans(i_trans_enable_in));
    task give_verdict;
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    // One bus transfer; the request holds until ready is seen high.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge i_mclk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1 && n < 16) begin
            @(posedge i_mclk);
            n++;
        end
        if (n == 16) begin
            failures++;
            give_verdict();
        end
        r = o_prdata;
        e = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask : wr
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        cmp(n, x, r);
    endtask : rdc
    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        rdc("trap_control", 12'h000, 32'h0001_003F);
        rdc("edge_control", 12'h004, 32'h0000_0000);
        rdc("source_select", 12'h008, 32'h0000_0000);
        rdc("active_level", 12'h00C, 32'h0000_003F);
        apb(12'h100, 1'b0, 32'h0, r, e);
        cmp("unmapped_err", 32'h0000_0001, {31'h0, e});
    endtask : t_reset
    // Only defined fields are written; reserved bits must still read as zero.
    task automatic t_resv;
        for (int i = 0; i < 3; i++) begin
            wr(12'(i * 4), i == 0 ? 32'h0000_002A : 32'h0000_00FF);
            rdc("reserved", 12'(i * 4), i == 0 ? 32'h0000_002A : 32'h0000_00FF);
            wr(12'(i * 4), i == 0 ? 32'h0001_003F : 32'h0000_0000);
        end
    endtask : t_resv
    task automatic t_trap;
        i_pwm_raw <= 6'h39;
        wr(12'h000, 32'h0001_0015);
        cmp("pwm_idle", 32'h0000_0039, {26'h0, o_pwm});
        src.drive(6'h01);
        repeat (5) @(posedge i_mclk);
        cmp("pwm_trapped", 32'h0000_0028, {26'h0, o_pwm});
        src.drive(6'h00);
        repeat (5) @(posedge i_mclk);
        cmp("trap_released", 32'h0, {31'h0, o_trap_active});
        wr(12'h00C, 32'h0000_000F);
        repeat (2) @(posedge i_mclk);
        cmp("pwm_low_active", 32'h0000_0009, {26'h0, o_pwm});
        wr(12'h000, 32'h0000_003F);
        src.drive(6'h01);
        repeat (5) @(posedge i_mclk);
        cmp("trap_high_inactive", 32'h0, {31'h0, o_trap_active});
        src.drive(6'h00);
        repeat (5) @(posedge i_mclk);
        cmp("pwm_trapped_low", 32'h0000_0030, {26'h0, o_pwm});
        src.drive(6'h01);
        wr(12'h00C, 32'h0000_003F);
    endtask : t_trap
    // Channel 0 on its pin through every edge code; trap line now idles high.
    task automatic t_cap_edge;
        logic [1:0]  c;
        logic [15:0] last;
        for (int k = 0; k < 4; k++) begin
            c = 2'((k + 1) % 4);
            wr(12'h004, {30'h0, c});
            i_pwm_counter_value <= 16'(16'h1000 + k);
            src.drive(6'h03);
            repeat (5) @(posedge i_mclk);
            if (c[0]) last = 16'(16'h1000 + k);
            rdc("capture0_rise", 12'h010, {16'h0, last});
            i_pwm_counter_value <= 16'(16'h2000 + k);
            src.drive(6'h01);
            repeat (5) @(posedge i_mclk);
            if (c[1]) last = 16'(16'h2000 + k);
            rdc("capture0_fall", 12'h010, {16'h0, last});
        end
    endtask : t_cap_edge
    // Channel 3 from every source, channel 2 beside it on the shared pin.
    task automatic t_cap_src;
        logic [15:0] v;
        logic [5:0]  b;
        wr(12'h004, 32'h0000_0050);
        for (int s = 0; s < 4; s++) begin
            wr(12'h008, {24'h0, 2'(s), 6'h0});
            v = 16'(16'h0300 + s);
            i_pwm_counter_value <= v;
            b = s == 0 ? 6'h08 : s == 1 ? 6'h10 : s == 2 ? 6'h01 : 6'h20;
            src.drive(6'h01 ^ b);
            repeat (5) @(posedge i_mclk);
            src.drive(6'h01);
            repeat (5) @(posedge i_mclk);
            rdc("capture3", 12'h01C, {16'h0, v});
            if (s == 0) rdc("capture2", 12'h018, {16'h0, v});
        end
    endtask : t_cap_src
    // Reset, then the scenarios in turn.
    initial begin
        i_psel              = 1'b0;
        i_penable           = 1'b0;
        i_pwrite            = 1'b0;
        i_nrst              = 1'b0;
        i_paddr             = 12'h000;
        i_pwdata            = 32'h0000_0000;
        i_pwm_counter_value = 16'h0000;
        i_pwm_raw           = 6'h00;
        repeat (5) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_reset();
        t_resv();
        t_trap();
        t_cap_edge();
        t_cap_src();
        give_verdict();
    end
endmodule : tb_pwm_trap_and_capture_control
bind ptc_top ptc_props u_props (.i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_mclk, .i_nrst, .i_emergency_trap_pin, .i_pwm_raw,
    .o_pwm, .o_trap_active);

// ---- design/ptc_edge_if.sv ----
`timescale 1ns/1ps
// Synchronised levels and one-cycle edge pulses of the asynchronous inputs.
interface ptc_edge_if;
    logic [5:0] level;
    logic [5:0] rise;
    logic [5:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : ptc_edge_if

// ---- design/ptc_edge_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser and edge detector for the asynchronous inputs.
module ptc_edge_sync (
    input  wire logic       i_mclk,
    input  wire logic       i_nrst,
    input  wire logic [5:0] i_async,
    ptc_edge_if.src         o_edges
);

    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
        logic [5:0] prev;
    } ptc_sync_s;

    ptc_sync_s st_q;
    ptc_sync_s st_d;

    // The first stage feeds only the second; edges compare stage two with its delayed copy.
    always_comb begin
        st_d      = st_q;
        st_d.meta = i_async;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Each qualifying edge yields exactly one pulse.
    assign o_edges.level = st_q.sync;
    assign o_edges.rise  = st_q.sync & ~st_q.prev;
    assign o_edges.fall  = ~st_q.sync & st_q.prev;

endmodule : ptc_edge_sync

// ---- design/ptc_pkg.sv ----
package ptc_pkg;

    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned N_OUT       = 6;
    localparam int unsigned N_CHAN      = 4;
    localparam int unsigned N_SRC       = 6;

    // Register byte offsets.
    localparam logic [11:0] OFS_TRAP    = 12'h000;
    localparam logic [11:0] OFS_EDGE    = 12'h004;
    localparam logic [11:0] OFS_SRC     = 12'h008;
    localparam logic [11:0] OFS_ACTLVL  = 12'h00C;
    localparam logic [11:0] OFS_CAPT0   = 12'h010;

    // Field positions.
    localparam int unsigned TRAP_POLARITY_BIT = 16;

    // Reset values.
    localparam logic        RST_TRAP_POLARITY = 1'h1;
    localparam logic [5:0]  RST_TRAP_OUTPUT_ENABLE = 6'h3F;
    localparam logic [7:0]  RST_EDGE     = 8'h00;
    localparam logic [7:0]  RST_SRC      = 8'h00;
    localparam logic [5:0]  RST_ACTLVL   = 6'h3F;

    // Synchronised input indices.
    localparam int unsigned IN_TRAP  = 0;
    localparam int unsigned IN_CAP0  = 1;
    localparam int unsigned IN_SYNC  = 4;
    localparam int unsigned IN_TRANS = 5;

    // Capture source codes.
    localparam logic [1:0] SRC_PIN   = 2'h0;
    localparam logic [1:0] SRC_SYNC  = 2'h1;
    localparam logic [1:0] SRC_TRAP  = 2'h2;
    localparam logic [1:0] SRC_TRANS = 2'h3;

    typedef enum {
        PTC_REG_TRAP,
        PTC_REG_EDGE,
        PTC_REG_SRC,
        PTC_REG_ACTLVL,
        PTC_REG_CAPTURE_REGISTER,
        PTC_REG_NONE
    } ptc_reg_e;

endpackage : ptc_pkg

// ---- design/ptc_top.sv ----
`timescale 1ns/1ps
// Trap and capture front end of a six-output PWM unit, with an APB register slave.
module ptc_top (
    input  wire logic [11:0] i_paddr,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_emergency_trap_pin,
    input  wire logic [2:0]  i_external_capture_pin,
    input  wire logic        i_sync_in,
    input  wire logic        i_trans_enable_in,
    input  wire logic [15:0] i_pwm_counter_value,
    input  wire logic [5:0]  i_pwm_raw,
    output logic      [5:0]  o_pwm,
    output logic             o_trap_active
);

    typedef struct packed {
        logic             trap_polarity;
        logic [5:0]       trap_output_enable;
        logic [7:0]       edge_sel;
        logic [7:0]       src_sel;
        logic [5:0]       output_active_level;
        logic [3:0][15:0] capture_register;
        logic             trapped;
        logic [5:0]       pwm;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } ptc_state_s;

    // Current state and its next value.
    ptc_state_s st_q;
    ptc_state_s st_d;

    // Synchronised levels and edge pulses of the asynchronous inputs.
    ptc_edge_if edges ();

    // Glue between the decoders and the state update.
    logic [5:0] async_in;
    logic [3:0] trig;
    logic       trap_edge;
    logic       trap_idle;
    logic       wr_en;
    logic       rd_setup;

    // Decode a byte address into a register selector.
    function automatic ptc_pkg::ptc_reg_e reg_decode(input logic [11:0] addr);
        ptc_pkg::ptc_reg_e sel;
        sel = ptc_pkg::PTC_REG_NONE;
        if (addr == ptc_pkg::OFS_TRAP) begin
            sel = ptc_pkg::PTC_REG_TRAP;
        end else if (addr == ptc_pkg::OFS_EDGE) begin
            sel = ptc_pkg::PTC_REG_EDGE;
        end else if (addr == ptc_pkg::OFS_SRC) begin
            sel = ptc_pkg::PTC_REG_SRC;
        end else if (addr == ptc_pkg::OFS_ACTLVL) begin
            sel = ptc_pkg::PTC_REG_ACTLVL;
        end else if (addr[11:4] == ptc_pkg::OFS_CAPT0[11:4] && addr[1:0] == 2'h0) begin
            sel = ptc_pkg::PTC_REG_CAPTURE_REGISTER;
        end
        return sel;
    endfunction : reg_decode

    // Qualify the rise and fall pulses of a selected input with a two-bit edge code.
    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic       rise,
                                      input logic       fall);
        return (code[0] & rise) | (code[1] & fall);
    endfunction : edge_hit

    // Level of one output: a trapped enabled output takes its inactive level.
    function automatic logic out_level(input logic trapped,
                                       input logic enable,
                                       input logic act,
                                       input logic raw);
        logic lvl;
        lvl = raw ~^ act;
        if (trapped && enable) begin
            lvl = ~act;
        end
        return lvl;
    endfunction : out_level

    // Read data of one register; reserved bits stay zero.
    function automatic logic [31:0] read_word(input ptc_state_s  s,
                                              input logic [11:0] addr);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (reg_decode(addr))
            ptc_pkg::PTC_REG_TRAP: begin
                w[ptc_pkg::TRAP_POLARITY_BIT] = s.trap_polarity;
                w[5:0]                   = s.trap_output_enable;
            end
            ptc_pkg::PTC_REG_EDGE:   w[7:0]  = s.edge_sel;
            ptc_pkg::PTC_REG_SRC:    w[7:0]  = s.src_sel;
            ptc_pkg::PTC_REG_ACTLVL: w[5:0]  = s.output_active_level;
            ptc_pkg::PTC_REG_CAPTURE_REGISTER:   w[15:0] = s.capture_register[addr[3:2]];
            default:                 w       = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    // Pins 0 to 2 feed channels; pin 2 also serves channel 3.
    assign async_in = {i_trans_enable_in,      // Index 5.
                       i_sync_in,              // Index 4.
                       i_external_capture_pin, // Indices 3 to 1.
                       i_emergency_trap_pin};  // Index 0.

    ptc_edge_sync u_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (async_in),
        .o_edges (edges.src)
    );

    // The trap fires on the edge that enters its active level, per polarity.
    assign trap_edge = st_q.trap_polarity ? edges.rise[ptc_pkg::IN_TRAP]
                                          : edges.fall[ptc_pkg::IN_TRAP];
    assign trap_idle = edges.level[ptc_pkg::IN_TRAP] != st_q.trap_polarity;

    // Per-channel trigger: select source, then qualify with the edge select code.
    generate
        for (genvar ch = 0; ch < ptc_pkg::N_CHAN; ch++) begin : g_chan
            localparam int unsigned PIN = (ch == 3) ? 2 : ch;
            logic [1:0] src;
            logic [1:0] edg;
            int unsigned idx;
            always_comb begin
                src = st_q.src_sel[2*ch +: 2];
                edg = st_q.edge_sel[2*ch +: 2];
                case (src)
                    ptc_pkg::SRC_PIN:   idx = ptc_pkg::IN_CAP0 + PIN;
                    ptc_pkg::SRC_SYNC:  idx = ptc_pkg::IN_SYNC;
                    ptc_pkg::SRC_TRAP:  idx = ptc_pkg::IN_TRAP;
                    ptc_pkg::SRC_TRANS: idx = ptc_pkg::IN_TRANS;
                    default:            idx = ptc_pkg::IN_CAP0 + PIN;
                endcase
                trig[ch] = edge_hit(edg, edges.rise[idx], edges.fall[idx]);
            end
        end
    endgenerate

    // Bus phases: writes land in the access phase, reads are prepared in setup.
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign rd_setup = i_psel & ~i_penable;

    // Next-state logic for registers, trap latch, outputs and bus answer.
    always_comb begin
        st_d = st_q;

        // Register writes; reserved bits are not stored.
        if (wr_en) begin
            case (reg_decode(i_paddr))
                ptc_pkg::PTC_REG_TRAP: begin
                    st_d.trap_polarity      = i_pwdata[ptc_pkg::TRAP_POLARITY_BIT];
                    st_d.trap_output_enable = i_pwdata[5:0];
                end
                ptc_pkg::PTC_REG_EDGE:   st_d.edge_sel = i_pwdata[7:0];
                ptc_pkg::PTC_REG_SRC:    st_d.src_sel = i_pwdata[7:0];
                ptc_pkg::PTC_REG_ACTLVL: st_d.output_active_level = i_pwdata[5:0];
                // Capture registers are read-only, so writes to them are dropped.
                ptc_pkg::PTC_REG_CAPTURE_REGISTER: ;
                default: ;
            endcase
        end

        // Counter snapshot on each channel trigger.
        for (int ch = 0; ch < ptc_pkg::N_CHAN; ch++) begin
            if (trig[ch]) begin
                st_d.capture_register[ch] = i_pwm_counter_value;
            end
        end

        // Trap latches on its edge and releases once the input is idle; the edge wins.
        if (trap_edge) begin
            st_d.trapped = 1'b1;
        end else if (trap_idle) begin
            st_d.trapped = 1'b0;
        end

        // Raw PWM is in active sense; trapped enabled outputs take the inactive level.
        for (int n = 0; n < ptc_pkg::N_OUT; n++) begin
            st_d.pwm[n] = out_level(st_d.trapped, st_q.trap_output_enable[n],
                                    st_q.output_active_level[n], i_pwm_raw[n]);
        end

        // Read data and error are prepared in the setup phase for the access phase.
        st_d.pready = 1'b1;
        if (rd_setup) begin
            st_d.prdata  = read_word(st_q, i_paddr);
            st_d.pslverr = reg_decode(i_paddr) == ptc_pkg::PTC_REG_NONE;
        end
    end

    // Register the whole state; reset loads the power-on settings.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q                     <= '0;
            st_q.trap_polarity       <= ptc_pkg::RST_TRAP_POLARITY;
            st_q.trap_output_enable  <= ptc_pkg::RST_TRAP_OUTPUT_ENABLE;
            st_q.edge_sel            <= ptc_pkg::RST_EDGE;
            st_q.src_sel             <= ptc_pkg::RST_SRC;
            st_q.output_active_level <= ptc_pkg::RST_ACTLVL;
        end else begin
            st_q <= st_d;
        end
    end

    // Every output comes straight from a state flop.
    assign o_pwm         = st_q.pwm;
    assign o_trap_active = st_q.trapped;
    assign o_prdata      = st_q.prdata;
    assign o_pready      = st_q.pready;
    assign o_pslverr     = st_q.pslverr;

endmodule : ptc_top
